// ==== hdl/rsc_pkg.sv ====
`default_nettype none

package rsc_pkg;

    // ---------------------------------------------
    // Timing
    // ---------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_RST_MAX_NS  = 2500;
    // Shortest pin pulse that asserts reset, rounded down
    localparam int PIN_FILT_CYC  = T_RST_MAX_NS / CLK_PERIOD_NS;
    localparam int BOD_QUAL_DEF  = 2;
    localparam int TOUT_BASE_DEF = 64;

    // ---------------------------------------------
    // Widths
    // ---------------------------------------------
    localparam int ADDR_W = 4;
    localparam int CNT_W  = 16;
    localparam int FILT_W = 8;

    // ---------------------------------------------
    // Register map
    // ---------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_FLAGS  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;

    localparam int FLAG_POR  = 0;
    localparam int FLAG_PIN  = 1;
    localparam int FLAG_BOD  = 2;
    localparam int FLAG_WDOG = 3;
    localparam logic [3:0] FLAGS_RST = 4'h1;

    localparam int CTRL_WDT_EN = 0;
    localparam int CTRL_COMPARATOR_BANDGAP_SEL   = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    localparam int STAT_RESET  = 0;
    localparam int STAT_PIN    = 1;
    localparam int STAT_BOD    = 2;
    localparam int STAT_BG     = 3;
    localparam int STAT_PHASE  = 4;

    // ---------------------------------------------
    // Brown-out level codes
    // ---------------------------------------------
    localparam logic [2:0] BOD_OFF    = 3'h7;
    localparam logic [2:0] BOD_LVL_LO = 3'h5;
    localparam logic [2:0] BOD_LVL_HI = 3'h4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PH_HOLD  = 2'h0,
        PH_COUNT = 2'h1,
        PH_RUN   = 2'h3,
        PH_WDOG  = 2'h2
    } rsc_phase_e;

    typedef enum logic [1:0] {
        SEL_FLAGS  = 2'h0,
        SEL_CTRL   = 2'h1,
        SEL_STATUS = 2'h2,
        SEL_NONE   = 2'h3
    } rsc_sel_e;

    typedef struct packed {
        logic       pin_reset_disable;
        logic [2:0] brownout_level_sel;
        logic [3:0] clock_source_sel;
        logic [1:0] startup_time_sel;
    } rsc_fuse_s;

    typedef struct packed {
        rsc_phase_e        phase;
        logic [CNT_W-1:0]  cnt;
        logic [FILT_W-1:0] pin_cnt;
        logic [FILT_W-1:0] bod_cnt;
        logic              pin_src;
        logic              bod_src;
        logic              sys_reset;
        logic [3:0]        flags;
        logic [1:0]        ctrl;
        logic              bod_en;
        logic              bod_lvl_hi;
        logic              bandgap_en;
        logic              aw_have;
        logic [ADDR_W-1:0] awaddr;
        logic              w_have;
        logic [7:0]        wdata;
        logic              wstrb0;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } rsc_state_s;

endpackage : rsc_pkg

`default_nettype wire

// ==== hdl/rsc_reset_source_controller.sv ====
// What this block does
// - Reset from power-on, pin, watchdog, brown-out
// - Long enough pin low pulse asserts reset
// - Pin release starts delay, then leave reset
// - Supply up starts delay; supply drop reasserts instantly
// - Fuse disables the reset pin function
// - Level code: 111 off, 101/100 levels
// - Enabled brown-out below level resets after qualification
// - Supply above upper level starts delay
// - Brown-out ignores drops shorter than qualification
// - Watchdog resets only in system-reset mode
// - Watchdog reset pulse lasts one clock
// - Delay starts at end of watchdog pulse
// - Cause register bits 7..4 read zero
// - Bit 3 watchdog flag, cleared by POR/write-zero
// - Bit 2 brown-out flag, cleared by POR/write-zero
// - Bit 1 pin flag, cleared by POR/write-zero
// - Bit 0 power-on flag, cleared by write-zero
// - Bandgap on for brown-out, comparator or converter
// - Delay length from clock and start-up fuses
// - Reset returns peripherals to initial values
`default_nettype none

module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int TOUT_BASE_CYC = TOUT_BASE_DEF,
    parameter int BOD_QUAL_CYC  = BOD_QUAL_DEF
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Nonvolatile settings
    input  wire rsc_fuse_s         fuse,
    // Reset sources
    input  wire logic              por_active,
    input  wire logic              pin_reset_n,
    input  wire logic              wdt_timeout,
    input  wire logic              bod_below,
    input  wire logic              bod_above,
    // Reference requests
    input  wire logic              adc_enable,
    // Chip-wide outputs
    output logic                   sys_reset,
    output logic                   bod_enable,
    output logic                   bod_level_hi,
    output logic                   bandgap_enable,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    function automatic rsc_sel_e decode(input logic [ADDR_W-1:0] a);
        rsc_sel_e r;
        case (a)
            ADDR_FLAGS:  r = SEL_FLAGS;
            ADDR_CTRL:   r = SEL_CTRL;
            ADDR_STATUS: r = SEL_STATUS;
            default:     r = SEL_NONE;
        endcase
        return r;
    endfunction : decode

    // Scaled per fuse pair; base is a parameter so sims can shorten
    function automatic logic [CNT_W-1:0] tout_cycles(input rsc_fuse_s f);
        logic [2:0] sel;
        sel = {f.clock_source_sel[0], f.startup_time_sel};
        return CNT_W'(TOUT_BASE_CYC) << sel;
    endfunction : tout_cycles

    localparam logic [FILT_W-1:0] PIN_LIM = FILT_W'(PIN_FILT_CYC);
    localparam logic [FILT_W-1:0] BOD_LIM = FILT_W'(BOD_QUAL_CYC);

    localparam rsc_state_s ST_RST = '{
        phase:      PH_HOLD,
        cnt:        '0,
        pin_cnt:    '0,
        bod_cnt:    '0,
        pin_src:    1'b0,
        bod_src:    1'b0,
        sys_reset:  1'b1,
        flags:      FLAGS_RST,
        ctrl:       CTRL_RST,
        bod_en:     1'b0,
        bod_lvl_hi: 1'b0,
        bandgap_en: 1'b0,
        aw_have:    1'b0,
        awaddr:     '0,
        w_have:     1'b0,
        wdata:      8'h00,
        wstrb0:     1'b0,
        awready:    1'b1,
        wready:     1'b1,
        bvalid:     1'b0,
        bresp:      RESP_OKAY,
        arready:    1'b1,
        rvalid:     1'b0,
        rdata:      32'h0000_0000,
        rresp:      RESP_OKAY
    };

    rsc_state_s s_reg;
    rsc_state_s s_next;

    // ---------------------------------------------
    // Next state
    // ---------------------------------------------
    always_comb begin
        logic       any_src;
        logic       ev_pin;
        logic       ev_bod;
        logic       ev_wdog;
        logic [3:0] keep;
        rsc_sel_e   wsel;
        rsc_sel_e   rsel;
        any_src = 1'b0;
        ev_pin  = 1'b0;
        ev_bod  = 1'b0;
        ev_wdog = 1'b0;
        keep    = 4'hF;
        wsel    = decode(s_reg.awaddr);
        rsel    = decode(araddr);
        s_next  = s_reg;

        // Fuse decode; reserved codes leave the detector off
        s_next.bod_en = (fuse.brownout_level_sel == BOD_LVL_LO)
                     || (fuse.brownout_level_sel == BOD_LVL_HI);
        s_next.bod_lvl_hi = (fuse.brownout_level_sel == BOD_LVL_HI);
        s_next.bandgap_en = s_next.bod_en
                         | s_reg.ctrl[CTRL_COMPARATOR_BANDGAP_SEL]
                         | adc_enable;

        // Pin filter: clock based, so a stopped clock cannot see it
        if (pin_reset_n || fuse.pin_reset_disable) begin
            s_next.pin_cnt = '0;
        end else if (s_reg.pin_cnt != PIN_LIM) begin
            s_next.pin_cnt = s_reg.pin_cnt + FILT_W'(1);
        end
        s_next.pin_src = (s_next.pin_cnt == PIN_LIM);

        // Brown-out qualification and hysteresis
        if (!bod_below || !s_next.bod_en) begin
            s_next.bod_cnt = '0;
        end else if (s_reg.bod_cnt != BOD_LIM) begin
            s_next.bod_cnt = s_reg.bod_cnt + FILT_W'(1);
        end
        if (!s_next.bod_en) begin
            s_next.bod_src = 1'b0;
        end else if (s_next.bod_cnt == BOD_LIM) begin
            s_next.bod_src = 1'b1;
        end else if (bod_above) begin
            s_next.bod_src = 1'b0;
        end

        any_src = por_active | s_next.pin_src | s_next.bod_src;

        // Reset sequencer
        case (s_reg.phase)
            PH_HOLD: begin
                if (!any_src) begin
                    s_next.phase = PH_COUNT;
                    s_next.cnt   = tout_cycles(fuse);
                end
            end
            PH_COUNT: begin
                if (any_src) begin
                    s_next.phase = PH_HOLD;
                end else if (s_reg.cnt <= CNT_W'(1)) begin
                    s_next.phase = PH_RUN;
                    s_next.cnt   = '0;
                end else begin
                    s_next.cnt = s_reg.cnt - CNT_W'(1);
                end
            end
            PH_RUN: begin
                if (any_src) begin
                    s_next.phase = PH_HOLD;
                end else if (wdt_timeout && s_reg.ctrl[CTRL_WDT_EN]) begin
                    s_next.phase = PH_WDOG;
                end
            end
            PH_WDOG: begin
                if (any_src) begin
                    s_next.phase = PH_HOLD;
                end else begin
                    s_next.phase = PH_COUNT;
                    s_next.cnt   = tout_cycles(fuse);
                end
            end
            default: begin
                s_next.phase = PH_HOLD;
            end
        endcase

        // Output is the registered phase decode, no extra lag
        s_next.sys_reset = (s_next.phase != PH_RUN);

        ev_pin  = s_next.pin_src & ~s_reg.pin_src;
        ev_bod  = s_next.bod_src & ~s_reg.bod_src;
        ev_wdog = (s_next.phase == PH_WDOG) && (s_reg.phase != PH_WDOG);

        // ---------------------------------------------
        // Bus write
        // ---------------------------------------------
        if (awvalid && s_reg.awready) begin
            s_next.aw_have = 1'b1;
            s_next.awaddr  = awaddr;
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_have = 1'b1;
            s_next.wdata  = wdata[7:0];
            s_next.wstrb0 = wstrb[0];
        end
        if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
            s_next.aw_have = 1'b0;
            s_next.w_have  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = RESP_OKAY;
            case (wsel)
                SEL_FLAGS: begin
                    if (s_reg.wstrb0) begin
                        keep = s_reg.wdata[3:0];
                    end
                end
                SEL_CTRL: begin
                    if (s_reg.wstrb0) begin
                        s_next.ctrl = s_reg.wdata[1:0];
                    end
                end
                SEL_STATUS: begin
                    s_next.bresp = RESP_OKAY;
                end
                default: begin
                    s_next.bresp = RESP_SLVERR;
                end
            endcase
        end else if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        s_next.awready = ~s_next.aw_have;
        s_next.wready  = ~s_next.w_have;

        // Flags: writing zero clears, a same-cycle event still sets
        s_next.flags = s_reg.flags & keep;
        if (ev_wdog) begin
            s_next.flags[FLAG_WDOG] = 1'b1;
        end
        if (ev_bod) begin
            s_next.flags[FLAG_BOD] = 1'b1;
        end
        if (ev_pin) begin
            s_next.flags[FLAG_PIN] = 1'b1;
        end
        // Only power-on wipes the others; other resets keep them
        if (por_active) begin
            s_next.flags = FLAGS_RST;
        end

        // ---------------------------------------------
        // Bus read
        // ---------------------------------------------
        if (arvalid && s_reg.arready) begin
            s_next.arready = 1'b0;
            s_next.rvalid  = 1'b1;
            s_next.rresp   = RESP_OKAY;
            s_next.rdata   = 32'h0000_0000;
            case (rsel)
                SEL_FLAGS: begin
                    s_next.rdata[3:0] = s_reg.flags;
                end
                SEL_CTRL: begin
                    s_next.rdata[1:0] = s_reg.ctrl;
                end
                SEL_STATUS: begin
                    s_next.rdata[STAT_RESET] = s_reg.sys_reset;
                    s_next.rdata[STAT_PIN]   = s_reg.pin_src;
                    s_next.rdata[STAT_BOD]   = s_reg.bod_src;
                    s_next.rdata[STAT_BG]    = s_reg.bandgap_en;
                    s_next.rdata[STAT_PHASE +: 2] = s_reg.phase;
                end
                default: begin
                    s_next.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_reg.rvalid && rready) begin
            s_next.rvalid  = 1'b0;
            s_next.arready = 1'b1;
        end
    end

    // ---------------------------------------------
    // State register
    // ---------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s_reg <= ST_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------
    // Outputs
    // ---------------------------------------------
    assign sys_reset      = s_reg.sys_reset;
    assign bod_enable     = s_reg.bod_en;
    assign bod_level_hi   = s_reg.bod_lvl_hi;
    assign bandgap_enable = s_reg.bandgap_en;
    assign awready        = s_reg.awready;
    assign wready         = s_reg.wready;
    assign bresp          = s_reg.bresp;
    assign bvalid         = s_reg.bvalid;
    assign arready        = s_reg.arready;
    assign rdata          = s_reg.rdata;
    assign rresp          = s_reg.rresp;
    assign rvalid         = s_reg.rvalid;

endmodule : rsc_reset_source_controller

`default_nettype wire

// ==== verification/rsc_chk.sv ====
`default_nettype none

module rsc_chk
    import rsc_pkg::*;
#(
    parameter int TOUT_BASE_CYC = TOUT_BASE_DEF,
    parameter int BOD_QUAL_CYC  = BOD_QUAL_DEF
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Block inputs
    input wire rsc_fuse_s   fuse,
    input wire logic        por_active,
    input wire logic        pin_reset_n,
    input wire logic        bod_below,
    input wire logic        adc_enable,
    // Block outputs and read handshake
    input wire logic        sys_reset,
    input wire logic        bod_enable,
    input wire logic        bod_level_hi,
    input wire logic        bandgap_enable,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [FILT_W-1:0] pin_cnt;
    logic [FILT_W-1:0] bod_cnt;
    logic [CNT_W-1:0]  quiet_cnt;
    logic [1:0]        dec;
    logic [CNT_W-1:0]  tout;

    assign tout = CNT_W'(TOUT_BASE_CYC) << {fuse.clock_source_sel[0], fuse.startup_time_sel};

    // Saturating run lengths, so a stuck source cannot wrap back to zero
    always_ff @(posedge clock) begin
        if (rst || pin_reset_n || fuse.pin_reset_disable) pin_cnt <= '0;
        else if (pin_cnt != '1) pin_cnt <= pin_cnt + 1'b1;
        if (rst || !bod_below || !bod_enable) bod_cnt <= '0;
        else if (bod_cnt != '1) bod_cnt <= bod_cnt + 1'b1;
        if (rst || por_active) quiet_cnt <= '0;
        else if (quiet_cnt != '1) quiet_cnt <= quiet_cnt + 1'b1;
        dec <= {fuse.brownout_level_sel inside {BOD_LVL_LO, BOD_LVL_HI},
                fuse.brownout_level_sel == BOD_LVL_HI};
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_por_reasserts: assert property (por_active |=> sys_reset)
        else $error("power-on did not reset");
    a_pin_filter: assert property (pin_cnt >= FILT_W'(PIN_FILT_CYC) |-> sys_reset)
        else $error("long pin pulse ignored");
    a_bod_trigger: assert property (bod_cnt >= FILT_W'(BOD_QUAL_CYC) |-> sys_reset)
        else $error("brown-out ignored");
    a_stretch_held: assert property (!sys_reset |-> quiet_cnt >= tout)
        else $error("reset left too early");
    a_level_decode: assert property (!$past(rst) |-> {bod_enable, bod_level_hi} == dec)
        else $error("level code decoded wrongly");
    // Detector enable and reference follow the same fuse sample, so compare in-cycle
    a_bandgap_bod: assert property (bod_enable |-> bandgap_enable)
        else $error("reference off with brown-out on");
    a_bandgap_on: assert property (adc_enable |=> bandgap_enable)
        else $error("reference left off");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read not answered");
    a_read_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
endmodule : rsc_chk

bind rsc_reset_source_controller rsc_chk #(
    .TOUT_BASE_CYC(TOUT_BASE_CYC),
    .BOD_QUAL_CYC (BOD_QUAL_CYC)
) rsc_chk_i (.*);

`default_nettype wire

// ==== verification/rsc_supply_model.sv ====
`default_nettype none

module rsc_supply_model (
    // Clock
    input  wire logic clock,
    // Requests from the bench
    input  wire logic por_req,
    input  wire logic pin_req,
    input  wire logic bod_req,
    // Monitor and pin outputs
    output logic      por_active  = 1'b0,
    output logic      pin_reset_n = 1'b1,
    output logic      bod_below   = 1'b0,
    output logic      bod_above   = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;

    // Hysteresis: upper level seen only a cycle after the lower one clears
    always @(posedge clock) begin
        por_active  <= por_req;
        pin_reset_n <= !pin_req;
        bod_below   <= bod_req;
        bod_above   <= !bod_req && !bod_below;
    end
endmodule : rsc_supply_model

`default_nettype wire

// ==== verification/tb.sv ====
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rsc_pkg::*;

    localparam int TOUT_BASE_CYC = 2;
    localparam int BOD_QUAL_CYC  = 1;
    logic              clock = 1'b0;
    logic              rst;
    rsc_fuse_s         fuse;
    logic              por_req, pin_req, bod_req, wdt_timeout, adc_enable;
    logic              por_active, pin_reset_n, bod_below, bod_above;
    logic              sys_reset, bod_enable, bod_level_hi, bandgap_enable;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, m;
    logic [3:0]        wstrb, exp_flags;
    logic [1:0]        bresp, rresp;
    logic [1:0]        b_q[$];
    logic [33:0]       r_q[$];
    int                error_cnt = 0;
    int                n_compared = 0;
    int                cyc = 0;

    rsc_supply_model rsc_supply_model_i (.*);
    rsc_reset_source_controller #(.TOUT_BASE_CYC(TOUT_BASE_CYC), .BOD_QUAL_CYC(BOD_QUAL_CYC))
        rsc_reset_source_controller_i (.*);

    initial forever #25 clock = ~clock;

    // ---------------------------------------------
    // Checking and bus tasks
    // ---------------------------------------------
    task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wait_rst(input logic v, input int lim);
        for (int i = 0; i < lim && sys_reset !== v; i++) @(posedge clock);
        chk({33'h0, sys_reset}, {33'h0, v}, "sys_reset");
    endtask : wait_rst

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_q.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clock);
            if ((awready && awvalid) === 1'b1) aw_done = 1'b1;
            if ((wready && wvalid) === 1'b1) w_done = 1'b1;
            if (aw_done) awvalid <= 1'b0;
            if (w_done) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1) @(posedge clock);
        bready <= 1'b0;
    endtask : wr

    // Ready raised late on purpose, so the slave must hold its answer
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
        r_q.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        @(posedge clock);
        rready <= 1'b1;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd

    task automatic rd_flags;
        rd(ADDR_FLAGS, {28'h0, exp_flags}, RESP_OKAY);
    endtask : rd_flags

    task automatic pin_pulse(input int n);
        pin_req <= 1'b1;
        repeat (n) @(posedge clock);
        pin_req <= 1'b0;
    endtask : pin_pulse

    task automatic wdog_pulse;
        wdt_timeout <= 1'b1;
        @(posedge clock);
        wdt_timeout <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : wdog_pulse

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
        if ((bvalid && bready) === 1'b1) chk({32'h0, bresp}, {32'h0, b_q.pop_front()}, "bresp");
        if ((rvalid && rready) === 1'b1) chk({rresp, rdata}, r_q.pop_front(), "read");
    end

    always @(posedge clock) adc_enable <= 1'($urandom);

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        void'($urandom(32'h32A1FC90));
        rst = 1'b1;
        fuse = '{1'b0, BOD_OFF, 4'h0, 2'h1};
        {por_req, pin_req, bod_req, wdt_timeout, adc_enable} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        wait_rst(1'b0, 40);
        exp_flags = FLAGS_RST;
        rd_flags();
        rd(4'hC, 32'h0, RESP_SLVERR);
        wr(4'hC, $urandom, RESP_SLVERR);
        pin_pulse(PIN_FILT_CYC - 1);
        repeat (3) @(posedge clock);
        wait_rst(1'b0, 1);
        pin_pulse(PIN_FILT_CYC);
        wait_rst(1'b1, 4);
        wait_rst(1'b0, 30);
        exp_flags[FLAG_PIN] = 1'b1;
        rd_flags();
        fuse.pin_reset_disable <= 1'b1;
        pin_pulse(PIN_FILT_CYC + 10);
        wait_rst(1'b0, 1);
        fuse.pin_reset_disable <= 1'b0;
        m = $urandom;
        wr(ADDR_FLAGS, m, RESP_OKAY);
        exp_flags &= m[3:0];
        rd_flags();
        wr(ADDR_FLAGS, 32'h0, RESP_OKAY);
        exp_flags = 4'h0;
        rd_flags();
        for (int c = 0; c < 8; c++) begin
            fuse.brownout_level_sel <= 3'(c);
            bod_req <= 1'b1;
            repeat (4) @(posedge clock);
            wait_rst(3'(c) inside {BOD_LVL_LO, BOD_LVL_HI}, 1);
            bod_req <= 1'b0;
            repeat (2) @(posedge clock);
            wait_rst(1'b0, 30);
        end
        exp_flags[FLAG_BOD] = 1'b1;
        rd_flags();
        wdog_pulse();
        wait_rst(1'b0, 1);
        wr(ADDR_CTRL, {30'($urandom), 2'b01}, RESP_OKAY);
        wdog_pulse();
        wait_rst(1'b1, 1);
        wait_rst(1'b0, 30);
        exp_flags[FLAG_WDOG] = 1'b1;
        rd_flags();
        por_req <= 1'b1;
        repeat (3) @(posedge clock);
        wait_rst(1'b1, 1);
        por_req <= 1'b0;
        wait_rst(1'b0, 30);
        exp_flags = FLAGS_RST;
        rd_flags();
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
